// *** src/vgs_defs.svh ***
`ifndef VGS_DEFS_SVH
`define VGS_DEFS_SVH
`define VGS_PORT_MISC_WR     10'h3c2
`define VGS_PORT_STAT0       10'h3c2
`define VGS_PORT_MISC_RD     10'h3cc
`define VGS_PORT_SEQ_IDX     10'h3c4
`define VGS_PORT_SEQ_DATA    10'h3c5
`define VGS_PORT_FEAT_RD     10'h3ca
`define VGS_PORT_CRT_IDX_M   10'h3b4
`define VGS_PORT_CRT_DAT_M   10'h3b5
`define VGS_PORT_STAT1_M     10'h3ba
`define VGS_PORT_CRT_IDX_C   10'h3d4
`define VGS_PORT_CRT_DAT_C   10'h3d5
`define VGS_PORT_STAT1_C     10'h3da
`define VGS_IDX_RESET        3'h0
`define VGS_IDX_CLOCKING     3'h1
`define VGS_IDX_MAPMASK      3'h2
`define VGS_IDX_FONTMAP      3'h3
`define VGS_IDX_MEMMODE      3'h4
`define VGS_MISC_IOSEL       0
`define VGS_MISC_MEMEN       1
`define VGS_MISC_CLK_LO      2
`define VGS_MISC_CLK_HI      3
`define VGS_MISC_PAGE        5
`define VGS_MISC_HPOL        6
`define VGS_MISC_VPOL        7
`define VGS_ST0_IRQ          7
`define VGS_ST0_SENSE        4
`define VGS_ST1_VRTC         3
`define VGS_ST1_DISP         0
`define VGS_RST_ASYNC        0
`define VGS_RST_SYNC         1
`define VGS_CLK_DOT8         0
`define VGS_CLK_SHL2         2
`define VGS_CLK_DIV2         3
`define VGS_CLK_SHL4         4
`define VGS_CLK_OFF          5
`define VGS_MEM_EXT          1
`define VGS_MEM_ODDEVEN      2
`define VGS_MEM_CHAIN4       3
`define VGS_MSC_EXT7         7
`define VGS_MSC_EXT6         6
`define VGS_RESET_MISC       8'h00
`define VGS_RESET_SEQRST     8'h03
`define VGS_RESET_ZERO       8'h00
`define VGS_RESET_MAPMASK    8'h0f
`endif

// *** src/vgs_pkg.sv ***
package vgs_pkg;
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [9:0] addr;
      logic [7:0] wdata;
   } vgs_io_req_s;
   typedef struct packed {
      logic       vsync_neg;
      logic       hsync_neg;
      logic [1:0] dot_clk_sel;
      logic       dot_div2;
      logic       dot8;
      logic [1:0] load_rate;
      logic       screen_off;
      logic       host_mem_en;
      logic       page_upper;
      logic       mem_ext;
      logic       seq_run;
      logic       seq_halt_async;
   } vgs_ctrl_s;
   typedef enum logic [2:0] {
      VGS_RUN   = 3'b001,
      VGS_SYNC  = 3'b010,
      VGS_ASYNC = 3'b100
   } vgs_seq_e;
endpackage

// *** src/vgs_plane_sel.sv ***
`timescale 1ns/1ns
`include "vgs_defs.svh"
module vgs_plane_sel (
   // config
   input  wire logic [7:0] map_mask_in,
   input  wire logic [7:0] mem_mode_in,
   // host address
   input  wire logic [1:0] addr_lo_in,
   // plane enables
   output logic [3:0]      plane_en_out
);
   wire       chain4  = mem_mode_in[`VGS_MEM_CHAIN4];
   wire       oddeven = ~mem_mode_in[`VGS_MEM_ODDEVEN];
   wire [3:0] c4_sel  = 4'h1 << addr_lo_in;
   wire [3:0] oe_sel  = addr_lo_in[0] ? 4'ha : 4'h5;
   assign plane_en_out = chain4 ? c4_sel :
                         (oddeven ? (oe_sel & map_mask_in[3:0]) : map_mask_in[3:0]);
endmodule

// *** src/vgs_regs.sv ***
// Overview of operation
// - misc bit 0 moves crt timing and status 1 ports between mono and color
// - misc output written at 3c2, read back at 3cc
// - misc bits 7 and 6 set vertical and horizontal sync polarity
// - misc bits 3:2 select dot clock source a, b, or user
// - misc bit 1 enables host access to video memory
// - misc bit 5 picks 64KB page unless extended size bits set
// - status 0 bit 7 shows pending vertical retrace interrupt
// - status 0 bit 4 returns sampled monitor sense level
// - status 1 bit 3 shows vertical retrace active
// - status 1 bit 0 is one while display is blanked for retrace
// - status 1 bits 5:4 return plane pair chosen by the plane diagnostic select input
// - sequencer index at 3c4 holds 3-bit index used by data port
// - reset bit 1 low clears and halts sequencer synchronously
// - reset bit 0 low clears and halts sequencer immediately
// - clocking bit 5 blanks screen while syncs continue
// - clocking bits 4 and 2 set serializer load rate
// - clocking bit 3 halves the dot clock
// - clocking bit 0 chooses 9 or 8 dot character cell
// - map mask bits enable host writes per plane outside chain-four mode
// - font maps a and b formed from split bits, slot order interleaved
// - chain-four uses two low address bits to pick a plane
// - odd/even mode routes even to planes 0,2 and odd to 1,3
`timescale 1ns/1ns
`include "vgs_defs.svh"
module vgs_regs
   import vgs_pkg::*;
(
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   // host io
   input  wire vgs_pkg::vgs_io_req_s io_req_in,
   output logic [7:0]             io_rdata_out,
   output logic                   io_hit_out,
   output logic                   crt_sel_out,
   // video status
   input  wire logic              vrtc_irq_in,
   input  wire logic              vretrace_in,
   input  wire logic              display_off_in,
   input  wire logic [7:0]        plane_out_in,
   input  wire logic [1:0]        plane_diag_sel_in,
   input  wire logic              upper_data_monitor_sense_in,
   input  wire logic [7:0]        memory_size_control_in,
   // host memory path
   input  wire logic [1:0]        host_addr_lo_in,
   output logic [3:0]             plane_en_out,
   // controls
   output vgs_pkg::vgs_ctrl_s     ctrl_out,
   output logic [2:0]             font_map_a_out,
   output logic [2:0]             font_map_b_out,
   output logic [2:0]             font_slot_a_out,
   output logic [2:0]             font_slot_b_out
);
   import vgs_pkg::*;
   logic [7:0] misc_q, seqrst_q, clkmode_q, mapmask_q, fontmap_q, memmode_q;
   logic [2:0] idx_q;
   logic       sense_s1_q, sense_s2_q, irq_s1_q, irq_s2_q;
   logic       vr_s1_q, vr_s2_q, doff_s1_q, doff_s2_q;
   logic [7:0] pl_s1_q, pl_s2_q;
   vgs_seq_e   seq_q, seq_d;

   // the video-side status is asynchronous to this clock, so sync it first
   always_ff @(posedge clk_in) begin
      sense_s1_q <= upper_data_monitor_sense_in;
      sense_s2_q <= sense_s1_q;
      irq_s1_q   <= vrtc_irq_in;
      irq_s2_q   <= irq_s1_q;
      vr_s1_q    <= vretrace_in;
      vr_s2_q    <= vr_s1_q;
      doff_s1_q  <= display_off_in;
      doff_s2_q  <= doff_s1_q;
      pl_s1_q    <= plane_out_in;
      pl_s2_q    <= pl_s1_q;
   end

   wire [9:0] a       = io_req_in.addr;
   wire       color   = misc_q[`VGS_MISC_IOSEL];
   wire [9:0] st1_adr = color ? `VGS_PORT_STAT1_C : `VGS_PORT_STAT1_M;
   wire       crt_hit = color ? (a == `VGS_PORT_CRT_IDX_C || a == `VGS_PORT_CRT_DAT_C)
                              : (a == `VGS_PORT_CRT_IDX_M || a == `VGS_PORT_CRT_DAT_M);
   wire       wr_misc = io_req_in.wr && a == `VGS_PORT_MISC_WR;
   wire       wr_idx  = io_req_in.wr && a == `VGS_PORT_SEQ_IDX;
   wire       wr_dat  = io_req_in.wr && a == `VGS_PORT_SEQ_DATA;
   wire       wr_rst  = wr_dat && idx_q == `VGS_IDX_RESET;
   wire       wr_clk  = wr_dat && idx_q == `VGS_IDX_CLOCKING;
   wire       wr_mm   = wr_dat && idx_q == `VGS_IDX_MAPMASK;
   wire       wr_fm   = wr_dat && idx_q == `VGS_IDX_FONTMAP;
   wire       wr_mem  = wr_dat && idx_q == `VGS_IDX_MEMMODE;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         misc_q    <= `VGS_RESET_MISC;
         idx_q     <= 3'h0;
         seqrst_q  <= `VGS_RESET_SEQRST;
         clkmode_q <= `VGS_RESET_ZERO;
         mapmask_q <= `VGS_RESET_MAPMASK;
         fontmap_q <= `VGS_RESET_ZERO;
         memmode_q <= `VGS_RESET_ZERO;
      end else begin
         if (wr_misc) misc_q <= io_req_in.wdata;
         if (wr_idx)  idx_q  <= io_req_in.wdata[2:0];
         if (wr_rst)  seqrst_q  <= {6'h00, io_req_in.wdata[1:0]};
         if (wr_clk)  clkmode_q <= {2'h0, io_req_in.wdata[5:2], 1'b0, io_req_in.wdata[0]};
         if (wr_mm)   mapmask_q <= {4'h0, io_req_in.wdata[3:0]};
         if (wr_fm)   fontmap_q <= {2'h0, io_req_in.wdata[5:0]};
         if (wr_mem)  memmode_q <= {4'h0, io_req_in.wdata[3:1], 1'b0};
      end
   end

   // sequencer run state
   always_comb begin
      seq_d = seq_q;
      case (seq_q)
         VGS_RUN: begin
            if (!seqrst_q[`VGS_RST_ASYNC])     seq_d = VGS_ASYNC;
            else if (!seqrst_q[`VGS_RST_SYNC]) seq_d = VGS_SYNC;
         end
         VGS_SYNC, VGS_ASYNC: begin
            if (seqrst_q[1:0] == 2'b11) seq_d = VGS_RUN;
            else if (!seqrst_q[`VGS_RST_ASYNC]) seq_d = VGS_ASYNC;
            else seq_d = VGS_SYNC;
         end
         default: seq_d = VGS_RUN;
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) seq_q <= VGS_RUN;
      else        seq_q <= seq_d;
   end

   // status words
   logic [1:0] diag;
   always_comb begin
      case (plane_diag_sel_in)
         2'b00:   diag = {pl_s2_q[2], pl_s2_q[0]};
         2'b01:   diag = {pl_s2_q[5], pl_s2_q[4]};
         2'b10:   diag = {pl_s2_q[3], pl_s2_q[1]};
         default: diag = {pl_s2_q[7], pl_s2_q[6]};
      endcase
   end
   wire [7:0] st0 = {irq_s2_q, 2'b00, sense_s2_q, 4'h0};
   wire [7:0] st1 = {2'b00, diag, vr_s2_q, 2'b00, doff_s2_q};
   logic [7:0] seq_dat;
   always_comb begin
      case (idx_q)
         `VGS_IDX_RESET:    seq_dat = seqrst_q;
         `VGS_IDX_CLOCKING: seq_dat = clkmode_q;
         `VGS_IDX_MAPMASK:  seq_dat = mapmask_q;
         `VGS_IDX_FONTMAP:  seq_dat = fontmap_q;
         `VGS_IDX_MEMMODE:  seq_dat = memmode_q;
         default:           seq_dat = 8'h00;
      endcase
   end

   wire rd = io_req_in.rd;
   wire h_st0 = a == `VGS_PORT_STAT0;
   wire h_mis = a == `VGS_PORT_MISC_RD;
   wire h_idx = a == `VGS_PORT_SEQ_IDX;
   wire h_dat = a == `VGS_PORT_SEQ_DATA;
   wire h_fea = a == `VGS_PORT_FEAT_RD;
   wire h_st1 = a == st1_adr;
   wire rhit  = rd && (h_st0 || h_mis || h_idx || h_dat || h_fea || h_st1);
   wire whit  = io_req_in.wr && (a == `VGS_PORT_MISC_WR || h_idx || h_dat || h_st1);

   // read data registered so it is stable for the slow host strobe
   always_ff @(posedge clk_in) begin
      if (rst_in) io_rdata_out <= 8'h00;
      else if (rd) begin
         if (h_st0)      io_rdata_out <= st0;
         else if (h_mis) io_rdata_out <= misc_q;
         else if (h_idx) io_rdata_out <= {5'h00, idx_q};
         else if (h_dat) io_rdata_out <= seq_dat;
         else if (h_st1) io_rdata_out <= st1;
         else            io_rdata_out <= 8'h00;
      end
   end
   assign io_hit_out  = rhit || whit;
   assign crt_sel_out = crt_hit;

   // control decode
   wire ext_size = memory_size_control_in[`VGS_MSC_EXT7] ||
                   memory_size_control_in[`VGS_MSC_EXT6];
   wire [1:0] ldr = clkmode_q[`VGS_CLK_SHL4] ? 2'd2 :
                    (clkmode_q[`VGS_CLK_SHL2] ? 2'd1 : 2'd0);
   wire [1:0] csel = misc_q[`VGS_MISC_CLK_HI] ? 2'd2 : {1'b0, misc_q[`VGS_MISC_CLK_LO]};
   always_comb begin
      ctrl_out.vsync_neg      = misc_q[`VGS_MISC_VPOL];
      ctrl_out.hsync_neg      = misc_q[`VGS_MISC_HPOL];
      ctrl_out.dot_clk_sel    = csel;
      ctrl_out.dot_div2       = clkmode_q[`VGS_CLK_DIV2];
      ctrl_out.dot8           = clkmode_q[`VGS_CLK_DOT8];
      ctrl_out.load_rate      = ldr;
      ctrl_out.screen_off     = clkmode_q[`VGS_CLK_OFF];
      ctrl_out.host_mem_en    = misc_q[`VGS_MISC_MEMEN];
      ctrl_out.page_upper     = misc_q[`VGS_MISC_PAGE] && !ext_size;
      ctrl_out.mem_ext        = memmode_q[`VGS_MEM_EXT];
      ctrl_out.seq_run        = seq_q == VGS_RUN;
      ctrl_out.seq_halt_async = !seqrst_q[`VGS_RST_ASYNC];
   end
   assign font_map_a_out  = {fontmap_q[5], fontmap_q[3:2]};
   assign font_map_b_out  = {fontmap_q[4], fontmap_q[1:0]};
   assign font_slot_a_out = {font_map_a_out[1:0], font_map_a_out[2]};
   assign font_slot_b_out = {font_map_b_out[1:0], font_map_b_out[2]};

   vgs_plane_sel u_plane (
      .map_mask_in  (mapmask_q),
      .mem_mode_in  (memmode_q),
      .addr_lo_in   (host_addr_lo_in),
      .plane_en_out (plane_en_out)
   );

   // host leaves one idle cycle between strobes, so the readback comes two edges on
   sequence s_misc_wr_rd;
      wr_misc ##1 !wr_misc ##1 (io_req_in.rd && a == `VGS_PORT_MISC_RD && !io_req_in.wr);
   endsequence
   property p_misc_rb;
      @(posedge clk_in) disable iff (rst_in)
      s_misc_wr_rd |=> io_rdata_out == $past(io_req_in.wdata, 3);
   endproperty
   a_misc_rb: assert property (p_misc_rb) else $error("misc readback wrong");
   property p_idx;
      @(posedge clk_in) disable iff (rst_in)
      wr_idx |=> idx_q == $past(io_req_in.wdata[2:0]);
   endproperty
   a_idx: assert property (p_idx) else $error("index not held");
   property p_st1_port;
      @(posedge clk_in) disable iff (rst_in)
      (rd && a == (misc_q[`VGS_MISC_IOSEL] ? `VGS_PORT_STAT1_C : `VGS_PORT_STAT1_M))
         |=> io_rdata_out == $past(st1);
   endproperty
   a_st1_port: assert property (p_st1_port) else $error("status1 port wrong");
   property p_async;
      @(posedge clk_in) disable iff (rst_in)
      !seqrst_q[0] |=> seq_q == VGS_ASYNC;
   endproperty
   a_async: assert property (p_async) else $error("async halt missing");
   property p_sync;
      @(posedge clk_in) disable iff (rst_in)
      (seqrst_q[1:0] == 2'b01) |=> seq_q == VGS_SYNC;
   endproperty
   a_sync: assert property (p_sync) else $error("sync halt missing");
   property p_page;
      @(posedge clk_in) disable iff (rst_in)
      ext_size |-> !ctrl_out.page_upper;
   endproperty
   a_page: assert property (p_page) else $error("page not suppressed");
   property p_load;
      @(posedge clk_in) disable iff (rst_in)
      clkmode_q[4] |-> ctrl_out.load_rate == 2'd2;
   endproperty
   a_load: assert property (p_load) else $error("load rate wrong");
   property p_chain4;
      @(posedge clk_in) disable iff (rst_in)
      memmode_q[3] |-> $onehot(plane_en_out);
   endproperty
   a_chain4: assert property (p_chain4) else $error("chain4 not one plane");
   property p_sense;
      @(posedge clk_in) disable iff (rst_in)
      (rd && h_st0) |=> io_rdata_out[4] == $past(sense_s2_q);
   endproperty
   a_sense: assert property (p_sense) else $error("sense bit wrong");

   property p_crt_col;
      @(posedge clk_in) disable iff (rst_in)
      (a == `VGS_PORT_CRT_IDX_C || a == `VGS_PORT_CRT_DAT_C) |-> crt_sel_out == color;
   endproperty
   a_crt_col: assert property (p_crt_col) else $error("color crt decode wrong");
   property p_crt_mono;
      @(posedge clk_in) disable iff (rst_in)
      (a == `VGS_PORT_CRT_IDX_M || a == `VGS_PORT_CRT_DAT_M) |-> crt_sel_out == !color;
   endproperty
   a_crt_mono: assert property (p_crt_mono) else $error("mono crt decode wrong");
   property p_misc_hold;
      @(posedge clk_in) disable iff (rst_in)
      !wr_misc |=> $stable(misc_q);
   endproperty
   a_misc_hold: assert property (p_misc_hold) else $error("misc changed unasked");
   property p_clk_user;
      @(posedge clk_in) disable iff (rst_in)
      misc_q[`VGS_MISC_CLK_HI] |-> ctrl_out.dot_clk_sel == 2'd2;
   endproperty
   a_clk_user: assert property (p_clk_user) else $error("user clock not chosen");
   property p_mem_en;
      @(posedge clk_in) disable iff (rst_in)
      !misc_q[`VGS_MISC_MEMEN] |-> !ctrl_out.host_mem_en;
   endproperty
   a_mem_en: assert property (p_mem_en) else $error("host memory not gated");
   property p_irq;
      @(posedge clk_in) disable iff (rst_in)
      (rd && h_st0) |=> io_rdata_out[`VGS_ST0_IRQ] == $past(irq_s2_q);
   endproperty
   a_irq: assert property (p_irq) else $error("retrace irq bit wrong");
   property p_st0_rsvd;
      @(posedge clk_in) disable iff (rst_in)
      (rd && h_st0) |=> io_rdata_out[6:5] == 2'b00 && io_rdata_out[3:0] == 4'h0;
   endproperty
   a_st0_rsvd: assert property (p_st0_rsvd) else $error("status0 reserved set");
   property p_vrtc;
      @(posedge clk_in) disable iff (rst_in)
      (rd && h_st1) |=> io_rdata_out[`VGS_ST1_VRTC] == $past(vr_s2_q);
   endproperty
   a_vrtc: assert property (p_vrtc) else $error("retrace status wrong");
   property p_disp;
      @(posedge clk_in) disable iff (rst_in)
      (rd && h_st1) |=> io_rdata_out[`VGS_ST1_DISP] == $past(doff_s2_q);
   endproperty
   a_disp: assert property (p_disp) else $error("display status wrong");
   property p_idx_rd;
      @(posedge clk_in) disable iff (rst_in)
      (rd && h_idx) |=> io_rdata_out == {5'h00, $past(idx_q)};
   endproperty
   a_idx_rd: assert property (p_idx_rd) else $error("index readback wrong");
   property p_idx_keep;
      @(posedge clk_in) disable iff (rst_in)
      (wr_dat || (rd && h_dat)) |=> $stable(idx_q);
   endproperty
   a_idx_keep: assert property (p_idx_keep) else $error("data access moved index");
   // leaving either halt needs both reset bits high in the register
   sequence s_halt_req;
      seqrst_q[1:0] != 2'b11;
   endsequence
   sequence s_run_req;
      seqrst_q[1:0] == 2'b11;
   endsequence
   property p_resume;
      @(posedge clk_in) disable iff (rst_in)
      s_halt_req ##1 s_run_req |=> ctrl_out.seq_run;
   endproperty
   a_resume: assert property (p_resume) else $error("sequencer did not resume");
   property p_screen;
      @(posedge clk_in) disable iff (rst_in)
      clkmode_q[`VGS_CLK_OFF] |-> ctrl_out.screen_off;
   endproperty
   a_screen: assert property (p_screen) else $error("screen not blanked");
   property p_half;
      @(posedge clk_in) disable iff (rst_in)
      (!clkmode_q[`VGS_CLK_SHL4] && clkmode_q[`VGS_CLK_SHL2]) |-> ctrl_out.load_rate == 2'd1;
   endproperty
   a_half: assert property (p_half) else $error("half load rate wrong");
   property p_mask;
      @(posedge clk_in) disable iff (rst_in)
      (!memmode_q[`VGS_MEM_CHAIN4] && memmode_q[`VGS_MEM_ODDEVEN])
         |-> plane_en_out == mapmask_q[3:0];
   endproperty
   a_mask: assert property (p_mask) else $error("map mask not applied");
   property p_oddeven;
      @(posedge clk_in) disable iff (rst_in)
      (!memmode_q[`VGS_MEM_CHAIN4] && !memmode_q[`VGS_MEM_ODDEVEN])
         |-> (plane_en_out & (host_addr_lo_in[0] ? 4'h5 : 4'ha)) == 4'h0;
   endproperty
   a_oddeven: assert property (p_oddeven) else $error("odd even plane leak");
endmodule

// *** tb/vgs_host_model.sv ***
`timescale 1ns/1ns
module vgs_host_model
   import vgs_pkg::*;
(
   // clock
   input  wire logic            clk_in,
   // request to the block
   output vgs_pkg::vgs_io_req_s io_req_out
);
   import vgs_pkg::*;
   initial io_req_out = '0;
   // strobe launched at a falling edge and held across one rising edge
   task automatic io_cycle(input logic r, input logic w, input logic [9:0] a,
                           input logic [7:0] d);
      @(negedge clk_in);
      io_req_out = '{rd: r, wr: w, addr: a, wdata: d};
      @(negedge clk_in);
      io_req_out.rd = 1'b0;
      io_req_out.wr = 1'b0;
      // released data is inverted so a stale value cannot pass for a held one
      io_req_out.wdata = ~d;
   endtask
   // misc output goes out on its write port and comes back on its read port
   task automatic io_write(input logic [9:0] a, input logic [7:0] d);
      io_cycle(1'b0, 1'b1, a, d);
   endtask
   task automatic io_read(input logic [9:0] a);
      io_cycle(1'b1, 1'b0, a, 8'h00);
   endtask
   // index is always written before the data port is touched
   task automatic seq_write(input logic [2:0] i, input logic [7:0] d);
      io_write(10'h3c4, {5'h00, i});
      io_write(10'h3c5, d);
   endtask
endmodule

// *** tb/vgs_regs_tb_top.sv ***
`timescale 1ns/1ns
module vgs_regs_tb_top;
   import vgs_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   vgs_io_req_s io_req;
   logic [7:0]  io_rdata_out;
   logic        crt_sel_out;
   logic        vrtc_irq_in = 1'b0;
   logic        vretrace_in = 1'b0;
   logic        display_off_in = 1'b0;
   logic [7:0]  plane_out_in = 8'h00;
   logic [1:0]  plane_diag_sel_in = 2'h0;
   logic        sense = 1'b0;
   logic [7:0]  size_ctl = 8'h00;
   logic [1:0]  host_addr_lo_in = 2'h0;
   logic [3:0]  plane_en_out;
   vgs_ctrl_s   ctrl_out;
   logic [2:0]  map_a, map_b, slot_a, slot_b;
   logic [8:0]  exp_q[$];
   logic [8:0]  exp_v;
   logic [7:0]  v;
   logic        io_hit;
   logic        hit_seen = 1'b0;
   logic [9:0]  off_st1 = 10'h3da;
   logic [3:0]  pe, mk;
   logic [1:0]  pr;
   logic        rd_seen = 1'b0;
   int          errors = 0;
   int          checks = 0;
   logic [7:0]  msk [5] = '{8'h03, 8'h3d, 8'h0f, 8'h3f, 8'h0e};
   logic [7:0]  rv [5] = '{8'h03, 8'h00, 8'h0f, 8'h00, 8'h00};

   always #5 clk_in = ~clk_in;

   vgs_host_model u_host (.clk_in(clk_in), .io_req_out(io_req));

   vgs_regs u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .io_req_in(io_req),
      .io_rdata_out(io_rdata_out), .io_hit_out(io_hit), .crt_sel_out(crt_sel_out),
      .vrtc_irq_in(vrtc_irq_in), .vretrace_in(vretrace_in),
      .display_off_in(display_off_in), .plane_out_in(plane_out_in),
      .plane_diag_sel_in(plane_diag_sel_in), .upper_data_monitor_sense_in(sense),
      .memory_size_control_in(size_ctl), .host_addr_lo_in(host_addr_lo_in),
      .plane_en_out(plane_en_out), .ctrl_out(ctrl_out),
      .font_map_a_out(map_a), .font_map_b_out(map_b),
      .font_slot_a_out(slot_a), .font_slot_b_out(slot_b)
   );

   task automatic complete_run;
      if (errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
      // only the unused port 3c0 and the inactive status 1 port miss
      exp_q.push_back({!(a == 10'h3c0 || a == off_st1), e});
      u_host.io_read(a);
   endtask

   // read data is registered, so it is judged at the falling edge after the taking edge
   always @(posedge clk_in) begin
      rd_seen  <= io_req.rd;
      hit_seen <= io_hit;
   end
   always @(negedge clk_in) begin
      if (rd_seen === 1'b1) begin
         exp_v = exp_q.pop_front();
         chk(io_rdata_out, exp_v[7:0]);
         chk({7'h00, hit_seen}, {7'h00, exp_v[8]});
      end
   end

   initial begin
      #400000;
      errors++;
      complete_run();
   end

   initial begin
      void'($urandom(63789));
      repeat (16) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      rd_chk(10'h3cc, 8'h00);
      rd_chk(10'h3c4, 8'h00);
      for (int i = 0; i < 5; i++) begin
         u_host.io_write(10'h3c4, 8'(i));
         rd_chk(10'h3c5, rv[i]);
      end
      for (int n = 0; n < 20; n++) begin
         v = 8'($urandom);
         u_host.seq_write(3'(n % 5), v);
         rd_chk(10'h3c5, v & msk[n % 5]);
         rd_chk(10'h3c4, 8'(n % 5));
         case (n % 5)
            0: chk({6'h00, ctrl_out.seq_run, ctrl_out.seq_halt_async},
                   {6'h00, v[1:0] == 2'h3, ~v[0]});
            1: chk({ctrl_out.screen_off, ctrl_out.dot_div2, ctrl_out.dot8,
                    ctrl_out.load_rate, 3'h0},
                   {v[5], v[3], v[0], v[4] ? 2'h2 : {1'b0, v[2]}, 3'h0});
            3: begin
               chk({map_a, map_b, 2'h0}, {v[5], v[3:2], v[4], v[1:0], 2'h0});
               chk({slot_a, slot_b, 2'h0}, {v[3:2], v[5], v[1:0], v[4], 2'h0});
            end
            4: chk({7'h00, ctrl_out.mem_ext}, {7'h00, v[1]});
            default: ;
         endcase
      end
      // sync halt, async halt, then run again, so both halt paths always see traffic
      for (int k = 1; k < 4; k++) begin
         u_host.seq_write(3'h0, 8'(k));
         @(negedge clk_in);
         chk({7'h00, ctrl_out.seq_run}, {7'h00, k == 3});
      end
      // map mask alone, then chain-four, then odd/even
      for (int m = 0; m < 3; m++) begin
         v = 8'($urandom);
         mk = (m == 0) ? v[3:0] : 4'hf;
         u_host.seq_write(3'h2, {4'h0, mk});
         u_host.seq_write(3'h4, (m == 0) ? 8'h04 : ((m == 1) ? 8'h08 : 8'h00));
         for (int a = 0; a < 4; a++) begin
            @(negedge clk_in);
            host_addr_lo_in = a[1:0];
            #1;
            pe = (m == 0) ? mk : ((m == 1) ? 4'h1 << a : (a[0] ? 4'ha : 4'h5));
            chk({4'h0, plane_en_out}, {4'h0, pe});
         end
      end
      for (int r = 0; r < 8; r++) begin
         v = 8'($urandom) & 8'hef;
         @(negedge clk_in);
         size_ctl = (r < 4) ? 8'h00 : (r[0] ? 8'h80 : 8'h40);
         u_host.io_write(10'h3c2, v);
         off_st1 = v[0] ? 10'h3ba : 10'h3da;
         rd_chk(10'h3cc, v);
         chk({ctrl_out.vsync_neg, ctrl_out.hsync_neg, ctrl_out.dot_clk_sel,
              ctrl_out.host_mem_en, ctrl_out.page_upper, 2'h0},
             {v[7:6], v[3] ? 2'h2 : {1'b0, v[2]}, v[1], v[5] & (r < 4), 2'h0});
         u_host.io_cycle(1'b0, 1'b0, v[0] ? 10'h3d4 : 10'h3b4, 8'h00);
         chk({7'h00, crt_sel_out}, 8'h01);
         u_host.io_cycle(1'b0, 1'b0, v[0] ? 10'h3b5 : 10'h3d5, 8'h00);
         chk({7'h00, crt_sel_out}, 8'h00);
         rd_chk(v[0] ? 10'h3ba : 10'h3da, 8'h00);
      end
      for (int s = 0; s < 8; s++) begin
         v = 8'($urandom);
         @(negedge clk_in);
         {vrtc_irq_in, vretrace_in, display_off_in, sense} = v[3:0];
         plane_out_in = 8'($urandom);
         plane_diag_sel_in = s[1:0];
         case (s[1:0])
            2'h0: pr = {plane_out_in[2], plane_out_in[0]};
            2'h1: pr = plane_out_in[5:4];
            2'h2: pr = {plane_out_in[3], plane_out_in[1]};
            default: pr = plane_out_in[7:6];
         endcase
         u_host.io_write(10'h3c2, {7'h00, s[2]});
         off_st1 = s[2] ? 10'h3ba : 10'h3da;
         // status inputs pass a two-stage synchroniser
         repeat (3) @(negedge clk_in);
         rd_chk(10'h3c2, {v[3], 2'h0, v[0], 4'h0});
         rd_chk(s[2] ? 10'h3da : 10'h3ba, {2'h0, pr, v[2], 2'h0, v[1]});
      end
      rd_chk(10'h3c0, 8'h00);
      rd_chk(10'h3ca, 8'h00);
      u_host.io_write(10'h3da, 8'hff);
      rd_chk(10'h3cc, 8'h01);
      u_host.io_write(10'h3c4, 8'hfc);
      rd_chk(10'h3c4, 8'h04);
      repeat (2) @(negedge clk_in);
      complete_run();
   end
endmodule
